// File: logic/dpp_params.svh
// Constants for the dual port parallel interface
`ifndef DPP_PARAMS_SVH
`define DPP_PARAMS_SVH

// Control word recognition, low nibble
`define DPP_CMD_MODE_NIB  4'hf
`define DPP_CMD_ICW_NIB   4'h7
// Interrupt control word fields
`define DPP_ICW_EN        7
`define DPP_ICW_AND       6
`define DPP_ICW_HIGH      5
`define DPP_ICW_MASKF     4
// Pattern control fields
`define DPP_PMC_AND       1
`define DPP_PMC_HIGH      0
// Return from interrupt, two byte opcode
`define DPP_RETURN_FROM_INTERRUPT_OPCODE_PRE      8'hed
`define DPP_RETURN_FROM_INTERRUPT_OPCODE_OP       8'h4d
// Reset values
`define DPP_OUT_RST       8'h00
`define DPP_MASK_RST      8'hff
`define DPP_DIR_RST       8'hff
`define DPP_PMC_RST       2'h0
`define DPP_VEC_RST       8'h00
// Synchroniser width: 16 pins, 2 strobes, chain, 8 data, 6 bus
`define DPP_SYNC_W        33
`define DPP_BUF_W         8
`define DPP_BUF_D         2

`endif

// File: logic/dpp_pkg.sv
// Types for the dual port parallel interface
package dpp_pkg;
   typedef enum logic [1:0] {
      DPP_BYTE_OUT = 2'h0,
      DPP_BYTE_IN  = 2'h1,
      DPP_BIDIR    = 2'h2,
      DPP_BIT_CTL  = 2'h3
   } dpp_mode_e;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'h0,
      BUS_WR   = 2'h1,
      BUS_RD   = 2'h3,
      BUS_ACK  = 2'h2
   } dpp_bus_e;
   typedef enum logic [1:0] {
      FOL_NONE = 2'h0,
      FOL_DIR  = 2'h1,
      FOL_MASK = 2'h3
   } dpp_fol_e;
endpackage

// File: logic/dpp_buf.sv
// Two entry buffer with valid/ready on both sides
`include "dpp_params.svh"
module dpp_buf import dpp_pkg::*; (
   input  wire logic                  ref_clk,   // System clock
   input  wire logic                  rst_b,     // Async reset
   input  wire logic                  in_valid,  // Word offered
   output logic                       in_ready,  // Room for a word
   input  wire logic [`DPP_BUF_W-1:0] in_data,   // Word in
   output logic                       out_valid, // Word held
   input  wire logic                  out_ready, // Drain may take
   output logic [`DPP_BUF_W-1:0]      out_data   // Oldest word
);
   logic [`DPP_BUF_W-1:0] mem_q [`DPP_BUF_D];
   logic                  wp_q;
   logic                  rp_q;
   logic [1:0]            cnt_q;
   wire                   push = in_valid & in_ready;
   wire                   pop  = out_valid & out_ready;

   assign in_ready  = (cnt_q != 2'(`DPP_BUF_D));
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = mem_q[rp_q];

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q <= 2'h0;
         mem_q <= '{default: '0};
      end else begin
         if (push) begin
            mem_q[wp_q] <= in_data;
            wp_q        <= ~wp_q;
         end
         if (pop)
            rp_q <= ~rp_q;
         cnt_q <= cnt_q + 2'(push) - 2'(pop);
      end
   end
endmodule

// File: logic/dpp_port.sv
// One port: pins, handshake and pattern match
`include "dpp_params.svh"
module dpp_port import dpp_pkg::*; (
   input  wire logic       ref_clk,    // System clock
   input  wire logic       rst_b,      // Async reset
   input  wire dpp_mode_e  mode,       // Operating mode
   input  wire logic [7:0] dir,        // 1 = pin is input
   input  wire logic [7:0] mask,       // 1 = pin masked
   input  wire logic [1:0] pmc,        // Pattern control
   input  wire logic       out_wr,     // Host data write pulse
   input  wire logic [7:0] out_data,   // Host data
   input  wire logic       stb_act,    // Own strobe active
   input  wire logic       in_stb_act, // Strobe loading input
   input  wire logic [7:0] pin_in,     // Synced pin levels
   input  wire logic       buf_ready,  // Buffer has room
   output logic            buf_push,   // Captured word valid
   output logic [7:0]      buf_data,   // Captured word
   output logic [7:0]      pin_out_q,  // Output register
   output logic [7:0]      pin_oe_q,   // Pin drive enables
   output logic            rdy_q,      // Ready handshake
   output logic            evt_q       // Interrupt event pulse
);
   logic       stb_q;
   logic       in_stb_q;
   logic       full_q;
   logic       match_q;
   logic [7:0] cap_q;

   wire       is_out  = (mode == DPP_BYTE_OUT) | (mode == DPP_BIDIR);
   wire       is_in   = (mode == DPP_BYTE_IN) | (mode == DPP_BIDIR);
   wire       is_bit  = (mode == DPP_BIT_CTL);
   wire       ack_end = is_out & stb_q & ~stb_act;
   wire       in_end  = is_in & in_stb_q & ~in_stb_act;
   wire       full_d  = (is_out & out_wr) | (full_q & ~ack_end);
   wire [7:0] lvl     = pmc[`DPP_PMC_HIGH] ? pin_in : ~pin_in;
   wire       all_hit = (&(lvl | mask)) & ~(&mask);
   wire       any_hit = |(lvl & ~mask);
   wire       match   = is_bit & (pmc[`DPP_PMC_AND] ? all_hit : any_hit);
   wire       pat_evt = match & ~match_q;

   assign buf_push = in_end & buf_ready;
   assign buf_data = cap_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         stb_q     <= 1'b0;
         in_stb_q  <= 1'b0;
         full_q    <= 1'b0;
         match_q   <= 1'b0;
         cap_q     <= 8'h00;
         pin_out_q <= `DPP_OUT_RST;
         pin_oe_q  <= 8'h00;
         rdy_q     <= 1'b0;
         evt_q     <= 1'b0;
      end else begin
         stb_q    <= stb_act;
         in_stb_q <= in_stb_act;
         full_q   <= full_d;
         match_q  <= match;
         if (in_stb_act)
            cap_q <= pin_in;
         if (out_wr)
            pin_out_q <= out_data;
         evt_q <= ack_end | pat_evt;
         case (mode)
            DPP_BYTE_OUT: begin
               pin_oe_q <= 8'hff;
               rdy_q    <= full_d;
            end
            DPP_BYTE_IN: begin
               pin_oe_q <= 8'h00;
               rdy_q    <= buf_ready;
            end
            DPP_BIDIR: begin
               pin_oe_q <= {8{stb_act}};
               rdy_q    <= full_d;
            end
            default: begin
               pin_oe_q <= ~dir;
               rdy_q    <= 1'b0;
            end
         endcase
      end
   end
endmodule

// File: logic/dpp_top.sv
// Dual port parallel interface: host bus, ports, interrupt chain
`include "dpp_params.svh"
module dpp_top import dpp_pkg::*; (
   input  wire logic       ref_clk,                 // 20 MHz system clock
   input  wire logic       rst_b,                   // Async reset, active low
   input  wire logic       chip_en_b,               // Chip enable, low
   input  wire logic       rd_b,                    // Read strobe, low
   input  wire logic       io_request_strobe_b,     // I/O request, low
   input  wire logic       opcode_fetch_strobe_b,   // Opcode fetch, low
   input  wire logic       port_sel,                // 0 first, 1 second
   input  wire logic       cmd_sel,                 // 1 command, 0 data
   input  wire logic [7:0] host_d_in,               // Host data bus in
   output logic [7:0]      host_d_out_q,            // Host data bus out
   output logic            host_d_oe_q,             // Host data bus drive
   input  wire logic       priority_chain_in,       // Chain enable in
   output logic            priority_chain_out_q,    // Chain enable out
   output logic            int_req_oe_q,            // Pull interrupt low
   input  wire logic [7:0] porta_pin_in,            // First port pins in
   output logic [7:0]      porta_pin_out_q,         // First port pins out
   output logic [7:0]      porta_pin_oe_q,          // First port drive
   input  wire logic       porta_stb_b,             // First strobe, low
   output logic            porta_rdy_q,             // First ready
   input  wire logic [7:0] portb_pin_in,            // Second port pins in
   output logic [7:0]      portb_pin_out_q,         // Second port pins out
   output logic [7:0]      portb_pin_oe_q,          // Second port drive
   input  wire logic       portb_stb_b,             // Second strobe, low
   output logic            portb_rdy_q              // Second ready
);
   // Pin synchronisers, three stages, change taken when two agree
   logic [`DPP_SYNC_W-1:0] s1_q;
   logic [`DPP_SYNC_W-1:0] s2_q;
   logic [`DPP_SYNC_W-1:0] s3_q;
   logic [`DPP_SYNC_W-1:0] flt_q;
   wire  [`DPP_SYNC_W-1:0] asy = {portb_pin_in, porta_pin_in,
                                  portb_stb_b, porta_stb_b,
                                  priority_chain_in, host_d_in,
                                  cmd_sel, port_sel,
                                  opcode_fetch_strobe_b,
                                  io_request_strobe_b, rd_b, chip_en_b};

   genvar gi;
   generate
      for (gi = 0; gi < `DPP_SYNC_W; gi++) begin : g_sync
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               s1_q[gi]  <= 1'b1;
               s2_q[gi]  <= 1'b1;
               s3_q[gi]  <= 1'b1;
               flt_q[gi] <= 1'b1;
            end else begin
               s1_q[gi] <= asy[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi])
                  flt_q[gi] <= s3_q[gi];
            end
         end
      end
   endgenerate

   wire       ce_s    = ~flt_q[0];
   wire       rd_s    = ~flt_q[1];
   wire       io_request_strobe_s  = ~flt_q[2];
   wire       fetch_s = ~flt_q[3];
   wire       psel_s  = flt_q[4];
   wire       csel_s  = flt_q[5];
   wire [7:0] d_s     = flt_q[13:6];
   wire       chain_s = flt_q[14];
   wire [1:0] stb_s   = ~flt_q[16:15];
   wire [7:0] pin_s [2];
   assign pin_s[0] = flt_q[24:17];
   assign pin_s[1] = flt_q[32:25];

   // Host cycle decode
   wire wr_cyc  = ce_s & io_request_strobe_s & ~rd_s & ~fetch_s;
   wire rd_cyc  = ce_s & io_request_strobe_s & rd_s & ~fetch_s;
   wire ack_cyc = io_request_strobe_s & fetch_s;
   wire op_cyc  = fetch_s & rd_s & ~io_request_strobe_s;

   dpp_bus_e   bus_q;
   dpp_bus_e   bus_d;
   logic       op_q;
   logic       ed_q;
   logic [7:0] op_byte_q;
   logic       ack_hit_q;
   logic       ack_port_q;
   logic       rd_port_q;

   always_comb begin
      bus_d = bus_q;
      case (bus_q)
         BUS_IDLE: begin
            if (ack_cyc)
               bus_d = BUS_ACK;
            else if (rd_cyc)
               bus_d = BUS_RD;
            else if (wr_cyc)
               bus_d = BUS_WR;
         end
         BUS_WR:  bus_d = wr_cyc ? BUS_WR : BUS_IDLE;
         BUS_RD:  bus_d = rd_cyc ? BUS_RD : BUS_IDLE;
         BUS_ACK: bus_d = ack_cyc ? BUS_ACK : BUS_IDLE;
         default: bus_d = BUS_IDLE;
      endcase
   end

   wire wr_go  = (bus_q == BUS_IDLE) & (bus_d == BUS_WR);
   wire ack_go = (bus_q == BUS_IDLE) & (bus_d == BUS_ACK);
   wire rd_end = (bus_q == BUS_RD) & (bus_d != BUS_RD);
   wire op_end = op_q & ~op_cyc;
   wire return_from_interrupt_opcode   = op_end & ed_q & (op_byte_q == `DPP_RETURN_FROM_INTERRUPT_OPCODE_OP);

   // Per port registers
   dpp_mode_e  mode_q [2];
   dpp_fol_e   fol_q [2];
   logic [7:0] dir_q [2];
   logic [7:0] mask_q [2];
   logic [1:0] pmc_q [2];
   logic [7:0] vec_q [2];
   logic [7:0] in_q [2];
   logic [1:0] ie_q;
   logic [1:0] ip_q;
   logic [1:0] ius_q;
   logic [1:0] in_full_q;
   logic [1:0] out_wr;
   logic [1:0] evt;
   logic [1:0] load;
   logic [1:0] push;
   logic [1:0] bready;
   logic [1:0] bvalid;
   logic [1:0] rdy;
   logic [7:0] bdata [2];
   logic [7:0] bout [2];
   logic [7:0] pout [2];
   logic [7:0] poe [2];
   logic [7:0] rd_val [2];

   // Interrupt priority: first port first, nesting by in-service
   wire [1:0] req;
   assign req[0]   = ip_q[0] & ie_q[0] & ~ius_q[0];
   assign req[1]   = ip_q[1] & ie_q[1] & ~ius_q[1] & ~ius_q[0];
   wire int_req    = chain_s & (|req);
   wire ack_sel    = ~req[0];
   wire [1:0] clr_ius;
   assign clr_ius[0] = return_from_interrupt_opcode & chain_s & ius_q[0];
   assign clr_ius[1] = return_from_interrupt_opcode & chain_s & ~ius_q[0] & ius_q[1];
   wire a_bidir    = (mode_q[0] == DPP_BIDIR);

   generate
      for (gi = 0; gi < 2; gi++) begin : g_port
         wire sel    = (psel_s == 1'(gi));
         wire cmd_wr = wr_go & sel & csel_s;
         wire [1:0] nm = d_s[7:6];
         wire mode_ok = !(gi == 1 && nm == DPP_BIDIR);
         wire ack_me  = ack_go & int_req & (ack_sel == 1'(gi));
         wire in_stb  = (gi == 0 && a_bidir) ? stb_s[1] : stb_s[gi];

         assign out_wr[gi] = wr_go & sel & ~csel_s;
         assign load[gi]   = bvalid[gi] & ~in_full_q[gi];
         assign rd_val[gi] = (mode_q[gi] == DPP_BIT_CTL) ?
                             ((pin_s[gi] & dir_q[gi]) | (pout[gi] & ~dir_q[gi])) :
                             in_q[gi];

         dpp_buf u_buf (
            .ref_clk   (ref_clk),
            .rst_b     (rst_b),
            .in_valid  (push[gi]),
            .in_ready  (bready[gi]),
            .in_data   (bdata[gi]),
            .out_valid (bvalid[gi]),
            .out_ready (~in_full_q[gi]),
            .out_data  (bout[gi])
         );

         dpp_port u_port (
            .ref_clk    (ref_clk),
            .rst_b      (rst_b),
            .mode       (mode_q[gi]),
            .dir        (dir_q[gi]),
            .mask       (mask_q[gi]),
            .pmc        (pmc_q[gi]),
            .out_wr     (out_wr[gi]),
            .out_data   (d_s),
            .stb_act    (stb_s[gi]),
            .in_stb_act (in_stb),
            .pin_in     (pin_s[gi]),
            .buf_ready  (bready[gi]),
            .buf_push   (push[gi]),
            .buf_data   (bdata[gi]),
            .pin_out_q  (pout[gi]),
            .pin_oe_q   (poe[gi]),
            .rdy_q      (rdy[gi]),
            .evt_q      (evt[gi])
         );

         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               mode_q[gi]    <= DPP_BYTE_IN;
               fol_q[gi]     <= FOL_NONE;
               dir_q[gi]     <= `DPP_DIR_RST;
               mask_q[gi]    <= `DPP_MASK_RST;
               pmc_q[gi]     <= `DPP_PMC_RST;
               vec_q[gi]     <= `DPP_VEC_RST;
               in_q[gi]      <= 8'h00;
               ie_q[gi]      <= 1'b0;
               ip_q[gi]      <= 1'b0;
               ius_q[gi]     <= 1'b0;
               in_full_q[gi] <= 1'b0;
            end else begin
               if (cmd_wr) begin
                  if (fol_q[gi] == FOL_DIR) begin
                     dir_q[gi] <= d_s;
                     fol_q[gi] <= FOL_NONE;
                  end else if (fol_q[gi] == FOL_MASK) begin
                     mask_q[gi] <= d_s;
                     fol_q[gi]  <= FOL_NONE;
                  end else if (d_s[3:0] == `DPP_CMD_MODE_NIB) begin
                     if (mode_ok)
                        mode_q[gi] <= dpp_mode_e'(nm);
                     if (nm == DPP_BIT_CTL)
                        fol_q[gi] <= FOL_DIR;
                  end else if (d_s[3:0] == `DPP_CMD_ICW_NIB) begin
                     ie_q[gi]  <= d_s[`DPP_ICW_EN];
                     pmc_q[gi] <= {d_s[`DPP_ICW_AND], d_s[`DPP_ICW_HIGH]};
                     if (d_s[`DPP_ICW_MASKF])
                        fol_q[gi] <= FOL_MASK;
                  end else if (!d_s[0]) begin
                     vec_q[gi] <= {d_s[7:1], 1'b0};
                  end
               end
               if (load[gi])
                  in_q[gi] <= bout[gi];
               // Host read frees the input register; a new load wins
               in_full_q[gi] <= load[gi] |
                                (in_full_q[gi] & ~(rd_end & (rd_port_q == 1'(gi))));
               // New event wins over the acknowledge clear
               ip_q[gi]  <= evt[gi] | load[gi] | (ip_q[gi] & ~ack_me);
               ius_q[gi] <= ack_me | (ius_q[gi] & ~clr_ius[gi]);
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         bus_q <= BUS_IDLE;
      else
         bus_q <= bus_d;
   end

   // Return opcode watch over opcode fetches
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         op_q      <= 1'b0;
         ed_q      <= 1'b0;
         op_byte_q <= 8'h00;
      end else begin
         op_q <= op_cyc;
         if (op_cyc)
            op_byte_q <= d_s;
         if (op_end)
            ed_q <= (op_byte_q == `DPP_RETURN_FROM_INTERRUPT_OPCODE_PRE);
      end
   end

   // Host data bus drive and chain outputs
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_hit_q            <= 1'b0;
         ack_port_q           <= 1'b0;
         rd_port_q            <= 1'b0;
         host_d_out_q         <= 8'h00;
         host_d_oe_q          <= 1'b0;
         priority_chain_out_q <= 1'b0;
         int_req_oe_q         <= 1'b0;
      end else begin
         if (ack_go) begin
            ack_hit_q  <= int_req;
            ack_port_q <= ack_sel;
         end
         if (bus_q == BUS_IDLE)
            rd_port_q <= psel_s;
         if (bus_q == BUS_RD) begin
            host_d_out_q <= rd_val[rd_port_q];
            host_d_oe_q  <= 1'b1;
         end else if (bus_q == BUS_ACK && ack_hit_q) begin
            host_d_out_q <= vec_q[ack_port_q];
            host_d_oe_q  <= 1'b1;
         end else begin
            host_d_oe_q <= 1'b0;
         end
         priority_chain_out_q <= chain_s & ~(|ius_q);
         int_req_oe_q         <= int_req;
      end
   end

   // Pin outputs; second ready shows first input room in bidir mode
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         porta_pin_out_q <= `DPP_OUT_RST;
         porta_pin_oe_q  <= 8'h00;
         portb_pin_out_q <= `DPP_OUT_RST;
         portb_pin_oe_q  <= 8'h00;
         porta_rdy_q     <= 1'b0;
         portb_rdy_q     <= 1'b0;
      end else begin
         porta_pin_out_q <= pout[0];
         porta_pin_oe_q  <= poe[0];
         portb_pin_out_q <= pout[1];
         portb_pin_oe_q  <= poe[1];
         porta_rdy_q     <= rdy[0];
         portb_rdy_q     <= a_bidir ? bready[0] : rdy[1];
      end
   end
endmodule

// File: tb/dpp_top_monitor.sv
// Concurrent checks on the parallel interface top ports
module dpp_top_monitor import dpp_pkg::*; (
   input wire logic       ref_clk,               // Clock
   input wire logic       rst_b,                 // Reset, low
   input wire logic       chip_en_b,             // Chip enable
   input wire logic       rd_b,                  // Read strobe
   input wire logic       io_request_strobe_b,   // I/O request
   input wire logic       opcode_fetch_strobe_b, // Opcode fetch
   input wire logic       priority_chain_in,     // Chain in
   input wire logic       priority_chain_out_q,  // Chain out
   input wire logic       int_req_oe_q,          // Interrupt pull
   input wire logic       host_d_oe_q,           // Bus drive
   input wire logic [7:0] host_d_out_q,          // Bus data
   input wire logic [7:0] porta_pin_out_q,       // First port out
   input wire logic [7:0] portb_pin_oe_q,        // Second port drive
   input wire logic       porta_rdy_q,           // First ready
   input wire logic       porta_stb_b,           // First strobe
   input wire logic       portb_stb_b            // Second strobe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] idle_cnt_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // Quiet cycles on host and strobes, saturating
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b)
         idle_cnt_q <= 4'h0;
      else if (!io_request_strobe_b || !porta_stb_b || !portb_stb_b)
         idle_cnt_q <= 4'h0;
      else if (idle_cnt_q != 4'hf)
         idle_cnt_q <= idle_cnt_q + 4'h1;
   end
   a_chain_out_gate: assert property (!priority_chain_in [*8] |-> !priority_chain_out_q)
      else $error("chain out high while chain in low");
   a_int_chain_gate: assert property (!priority_chain_in [*8] |-> !int_req_oe_q)
      else $error("interrupt raised with chain in low");
   a_vec_lsb_zero: assert property ((!io_request_strobe_b && !opcode_fetch_strobe_b) [*8]
      |-> !host_d_oe_q || !host_d_out_q[0]) else $error("vector bit 0 set");
   a_bus_idle_quiet: assert property (io_request_strobe_b [*8] |-> ##4 !host_d_oe_q)
      else $error("bus driven with no cycle");
   a_write_no_drive: assert property ((!chip_en_b && !io_request_strobe_b && rd_b
      && opcode_fetch_strobe_b) [*8] |-> !host_d_oe_q) else $error("bus driven in write");
   a_out_reg_hold: assert property (io_request_strobe_b [*8] |-> $stable(porta_pin_out_q))
      else $error("output register moved without write");
   a_dir_hold: assert property (io_request_strobe_b [*8] |-> $stable(portb_pin_oe_q))
      else $error("pin drive moved without write");
   a_rdy_hold: assert property (idle_cnt_q >= 4'ha |-> $stable(porta_rdy_q))
      else $error("ready moved without handshake");
   c_ack: cover property (!io_request_strobe_b && !opcode_fetch_strobe_b && host_d_oe_q);
   c_int: cover property ($rose(int_req_oe_q));
   c_chain: cover property ($fell(priority_chain_out_q));
endmodule

// File: tb/dpp_periph.sv
// Peripheral model: strobed word sender or static pin driver
module dpp_periph import dpp_pkg::*; (
   input  wire logic       ref_clk, // Clock
   input  wire logic       rdy,     // Port ready
   input  wire logic [7:0] pin_out, // Port pin values
   input  wire logic [7:0] pin_oe,  // Port pin drives
   input  wire logic       send,    // Start one strobe
   input  wire logic       hold,    // Drive word statically
   input  wire logic       slow,    // Long strobe
   input  wire logic [7:0] word,    // Word to offer
   output logic            stb_b,   // Strobe, low
   output logic            busy,    // Strobe in progress
   output logic [7:0]      pin_in   // Resolved pin levels
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] drv = 8'h00;
   initial stb_b = 1'h1;
   initial busy = 1'h0;
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
   always begin
      @(posedge ref_clk);
      if (hold)
         drv <= word;
      else if (send) begin
         busy <= 1'h1;
         while (rdy !== 1'h1) @(posedge ref_clk);
         drv <= word;
         stb_b <= 1'h0;
         repeat (slow ? 20 : 6) @(posedge ref_clk);
         stb_b <= 1'h1;
         repeat (2) @(posedge ref_clk);
         drv <= ~word;
         busy <= 1'h0;
      end
   end
endmodule

// File: tb/tb.sv
// Self-checking bench for the dual port parallel interface
module tb import dpp_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'h0, rst_b = 1'h0, chip_en_b = 1'h1, rd_b = 1'h1, slow = 1'h0;
   logic        io_request_strobe_b = 1'h1, opcode_fetch_strobe_b = 1'h1, port_sel = 1'h0;
   logic        cmd_sel = 1'h0, priority_chain_in = 1'h1, host_d_oe_q, priority_chain_out_q;
   logic        int_req_oe_q, porta_stb_b, portb_stb_b, porta_rdy_q, portb_rdy_q;
   logic [1:0]  send = 2'h0, hold = 2'h0, busy;
   logic [7:0]  host_d_in = 8'h00, host_d_out_q, porta_pin_in, porta_pin_out_q, v, d0;
   logic [7:0]  porta_pin_oe_q, portb_pin_in, portb_pin_out_q, portb_pin_oe_q;
   logic [7:0]  wa = 8'h00, wb = 8'h00, q[$];
   logic [31:0] rs = 32'h2;
   int          failures = 0, total_checks = 0;
   always #25 ref_clk = ~ref_clk;
   dpp_top i_dut (.*);
   dpp_periph i_pa (.ref_clk, .rdy(porta_rdy_q), .pin_out(porta_pin_out_q), .pin_oe(porta_pin_oe_q),
      .send(send[0]), .hold(hold[0]), .slow, .word(wa), .stb_b(porta_stb_b), .busy(busy[0]),
      .pin_in(porta_pin_in));
   dpp_periph i_pb (.ref_clk, .rdy(portb_rdy_q), .pin_out(portb_pin_out_q), .pin_oe(portb_pin_oe_q),
      .send(send[1]), .hold(hold[1]), .slow, .word(wb), .stb_b(portb_stb_b), .busy(busy[1]),
      .pin_in(portb_pin_in));
   function automatic logic [7:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs[7:0];
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (failures == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Strobe code order: chip enable, request, read, fetch
   task automatic bus(input logic [3:0] s, input logic p, input logic c, input logic [7:0] d);
      int n;
      n = 0;
      {chip_en_b, io_request_strobe_b, rd_b, opcode_fetch_strobe_b} = s;
      {port_sel, cmd_sel, host_d_in} = {p, c, d};
      repeat (8) @(negedge ref_clk);
      while ((s == 4'h1 || s == 4'ha) && host_d_oe_q !== 1'h1 && n < 12) begin
         @(negedge ref_clk);
         n++;
      end
      v = host_d_oe_q ? host_d_out_q : 8'hxx;
      {chip_en_b, io_request_strobe_b, rd_b, opcode_fetch_strobe_b} = 4'hf;
      repeat (12) @(negedge ref_clk);
   endtask
   task automatic wr(input logic p, input logic c, input logic [7:0] d);
      bus(4'h3, p, c, d);
   endtask
   task automatic rd(input logic [3:0] s, input logic p, input logic [7:0] e);
      bus(s, p, 1'h0, 8'h00);
      check(v, e);
   endtask
   task automatic return_from_interrupt_opcode();
      bus(4'hc, 1'h0, 1'h0, 8'hed);
      bus(4'hc, 1'h0, 1'h0, 8'h4d);
   endtask
   task automatic xfer(input int k, input logic [7:0] w);
      int n;
      n = 0;
      v = rnd();
      slow = v[7];
      if (k == 0)
         wa = w;
      else
         wb = w;
      send[k] = 1'h1;
      @(negedge ref_clk);
      send[k] = 1'h0;
      while (busy[k] !== 1'h0 && n < 300) begin
         @(negedge ref_clk);
         n++;
      end
      repeat (10) @(negedge ref_clk);
   endtask
   initial begin
      #500000;
      failures++;
      conclude();
   end
   initial begin
      repeat (2) @(negedge ref_clk);
      check({4'h0, host_d_oe_q, int_req_oe_q, porta_rdy_q, portb_rdy_q}, 8'h00);
      check(porta_pin_oe_q | portb_pin_oe_q | porta_pin_out_q, 8'h00);
      @(negedge ref_clk);
      rst_b = 1'h1;
      repeat (10) @(negedge ref_clk);
      check({7'h0, porta_rdy_q}, 8'h01);
      wr(1'h0, 1'h1, 8'h0f);
      wr(1'h1, 1'h1, 8'h0f);
      for (int i = 0; i < 4; i++) begin
         d0 = rnd();
         wr(i[0], 1'h0, d0);
         check(i[0] ? portb_pin_out_q : porta_pin_out_q, d0);
         check(porta_pin_oe_q & portb_pin_oe_q, 8'hff);
         check({6'h0, porta_rdy_q, portb_rdy_q}, i[0] ? 8'h01 : 8'h02);
         xfer(i % 2, rnd());
         check({6'h0, porta_rdy_q, portb_rdy_q}, 8'h00);
      end
      wr(1'h1, 1'h1, 8'h8f);
      check(portb_pin_oe_q, 8'hff);
      wr(1'h0, 1'h1, 8'h8f);
      check(porta_pin_oe_q, 8'h00);
      hold[0] = 1'h1;
      wa = 8'h90;
      wr(1'h0, 1'h1, 8'hcf);
      wr(1'h0, 1'h1, 8'hf0);
      wr(1'h0, 1'h1, 8'h20);
      wr(1'h0, 1'h0, 8'h35);
      check(porta_pin_oe_q, 8'h0f);
      check({7'h0, porta_rdy_q}, 8'h00);
      rd(4'h1, 1'h0, 8'h95);
      wa = 8'h00;
      wr(1'h0, 1'h1, 8'hf7);
      wr(1'h0, 1'h1, 8'h3f);
      // Earlier output acks left the first port pending
      rd(4'ha, 1'h0, 8'h20);
      return_from_interrupt_opcode();
      wr(1'h1, 1'h1, 8'h4f);
      wr(1'h1, 1'h1, 8'h30);
      wr(1'h1, 1'h1, 8'h87);
      for (int i = 0; i < 3; i++) begin
         q.push_back(rnd());
         xfer(1, q[i]);
      end
      check({6'h0, portb_rdy_q, int_req_oe_q}, 8'h01);
      rd(4'ha, 1'h0, 8'h30);
      check({7'h0, priority_chain_out_q}, 8'h00);
      return_from_interrupt_opcode();
      check({7'h0, priority_chain_out_q}, 8'h01);
      wa = 8'h40;
      repeat (12) @(negedge ref_clk);
      check({7'h0, int_req_oe_q}, 8'h00);
      wa = 8'hc0;
      repeat (12) @(negedge ref_clk);
      check({7'h0, int_req_oe_q}, 8'h01);
      rd(4'ha, 1'h0, 8'h20);
      while (q.size() > 0)
         rd(4'h1, 1'h1, q.pop_front());
      check({6'h0, portb_rdy_q, int_req_oe_q}, 8'h02);
      return_from_interrupt_opcode();
      check({7'h0, int_req_oe_q}, 8'h01);
      rd(4'ha, 1'h0, 8'h30);
      return_from_interrupt_opcode();
      wa = 8'h00;
      wr(1'h0, 1'h1, 8'hb7);
      wr(1'h0, 1'h1, 8'h3f);
      wa = 8'h40;
      repeat (12) @(negedge ref_clk);
      check({7'h0, int_req_oe_q}, 8'h01);
      priority_chain_in = 1'h0;
      repeat (12) @(negedge ref_clk);
      check({6'h0, int_req_oe_q, priority_chain_out_q}, 8'h00);
      priority_chain_in = 1'h1;
      repeat (12) @(negedge ref_clk);
      rd(4'ha, 1'h0, 8'h20);
      return_from_interrupt_opcode();
      check({7'h0, priority_chain_out_q}, 8'h01);
      conclude();
   end
endmodule
bind dpp_top dpp_top_monitor i_mon (.*);
